// ---- eeprom_pkg.sv ----
// Constants, types and timing counts for the serial EEPROM slave.
// Assumes: compiled before every other file of the block.
`default_nettype none

package eeprom_pkg;

  // ---------------------------------------------------------------
  // Clock rates and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 5;
  localparam int unsigned LINK_PERIOD_NS      = 6;
  localparam int unsigned SCL_STD_MAX_KHZ     = 100;
  localparam int unsigned SCL_FAST_MAX_KHZ    = 400;
  localparam int unsigned GLITCH_FILTER_WIDTH_NS = 100;
  localparam int unsigned INTERNAL_WRITE_TIME_NS = 5000000;
  localparam int unsigned POWERUP_READY_DELAY_NS = 1000000;
  // Least time: a pulse must outlast the filter width, so round up.
  localparam int unsigned GLITCH_CYCLES =
    (GLITCH_FILTER_WIDTH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  // Longest time: the write cycle must end in time, so round down.
  localparam int unsigned WRITE_CYCLES = INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Array, page and address
  // ---------------------------------------------------------------
  localparam int unsigned MEM_BYTES_SMALL = 128;
  localparam int unsigned MEM_BYTES_LARGE = 256;
  localparam int unsigned PAGE_BYTES      = 16;
  localparam int unsigned PAGE_W          = 4;
  localparam logic [3:0]  DEV_TYPE        = 4'ha;
  localparam logic [2:0]  DEV_SEL         = 3'h0;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam logic [3:0]  BIT_ACK         = 4'h8;
  localparam logic [3:0]  BIT_ACK_DONE    = 4'h9;

  // ---------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EV_NONE, EV_START, EV_STOP, EV_RISE0, EV_RISE1, EV_FALL
  } ev_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_WORD, ST_WDATA, ST_RDATA
  } st_e;

endpackage

`default_nettype wire

// ---- eeprom_slave.sv ----
// Slave logic of a small two-wire serial EEPROM with page buffer.
// Assumes: link_clock is free running; reset_n stands for the supply monitor.
//
// Functional notes
// - Array holds 128 or 256 eight-bit bytes.
// - A sixteen-byte page buffer gathers one write session.
// - Bus clock up to 100 kHz standard, 400 kHz fast.
// - Fixed bus address, no selectable address bits.
// - Pulses of 100 ns or less on clock and data are ignored.
// - Supply reset forces reset state; release enters Standby.
// - Data sampled on clock rise, changed on clock fall.
// - Data line only pulled low or released, never driven high.
// - Write-protect high at the first data byte or at stop inhibits the array write.
// - Undriven write-protect reads as low.
// - Address 1010 then 000 selects device; last bit is read/write.
// - Page write wraps low address within the page.
// - Stop after data starts write cycle; no acknowledge meanwhile.
// - Write-protect strobed before first data byte; high rejects it.
`default_nettype none

module eeprom_slave #(
  parameter int unsigned MEM_BYTES    = eeprom_pkg::MEM_BYTES_LARGE,
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // System clock and reset.
  input  wire logic clock,
  input  wire logic reset_n,
  // Link clock for the pin side.
  input  wire logic link_clock,
  // Two-wire bus pins.
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Write protect pin.
  input  wire logic wp_i,
  // Internal write cycle in progress.
  output logic      write_busy
);

  localparam int unsigned ADDR_W  = $clog2(MEM_BYTES);
  localparam int unsigned TIMER_W = $clog2(WRITE_CYCLES + 1);
  localparam int unsigned PW      = eeprom_pkg::PAGE_W;

  if (MEM_BYTES != eeprom_pkg::MEM_BYTES_SMALL && MEM_BYTES != eeprom_pkg::MEM_BYTES_LARGE)
  begin : g_chk_mem
    $error("MEM_BYTES must be 128 or 256.");
  end
  if (WRITE_CYCLES < 1) begin : g_chk_wr
    $error("WRITE_CYCLES must be at least one.");
  end

  // ---------------------------------------------------------------
  // Link domain: filtering, event detection, data drive
  // ---------------------------------------------------------------
  event_if         lk ();
  logic            scl_f;
  logic            sda_f;
  logic            scl_p_q;
  logic            sda_p_q;
  eeprom_pkg::ev_e ev_d;
  logic            oe_meta_q;
  logic            oe_q;

  // Filter latency is far below a bit time at 400 kHz.
  pin_filter #(.STABLE_CYCLES(eeprom_pkg::GLITCH_CYCLES)) u_scl_filt (
    .clock   (link_clock),
    .reset_n (reset_n),
    .pin     (scl_i),
    .level   (scl_f)
  );

  pin_filter #(.STABLE_CYCLES(eeprom_pkg::GLITCH_CYCLES)) u_sda_filt (
    .clock   (link_clock),
    .reset_n (reset_n),
    .pin     (sda_i),
    .level   (sda_f)
  );

  // Previous filtered levels for edge detection.
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Data edges while the clock is high are start and stop.
  always_comb begin
    ev_d = eeprom_pkg::EV_NONE;
    if (scl_f && scl_p_q && sda_p_q && !sda_f) begin
      ev_d = eeprom_pkg::EV_START;
    end else if (scl_f && scl_p_q && !sda_p_q && sda_f) begin
      ev_d = eeprom_pkg::EV_STOP;
    end else if (scl_f && !scl_p_q) begin
      ev_d = sda_f ? eeprom_pkg::EV_RISE1 : eeprom_pkg::EV_RISE0;
    end else if (!scl_f && scl_p_q) begin
      ev_d = eeprom_pkg::EV_FALL;
    end
  end

  // Each event is held and announced by a toggle.
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      lk.code <= eeprom_pkg::EV_NONE;
      lk.tgl  <= 1'b0;
    end else if (ev_d != eeprom_pkg::EV_NONE) begin
      lk.code <= ev_d;
      lk.tgl  <= ~lk.tgl;
    end
  end

  logic drive_q;

  // The pull-low request crosses back through two flip-flops.
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      oe_meta_q <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      oe_meta_q <= drive_q;
      oe_q      <= oe_meta_q;
    end
  end

  assign sda_oe = oe_q;
  assign sda_o  = 1'b0;

  // ---------------------------------------------------------------
  // System domain: protocol, page buffer, array
  // ---------------------------------------------------------------
  logic              ev_valid;
  eeprom_pkg::ev_e   ev_code;
  eeprom_pkg::st_e   state_q;
  logic [3:0]        bitcnt_q;
  logic [7:0]        shreg_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        tx_q;
  logic              wp_m_q;
  logic              wp_s_q;
  logic              wp_blk_q;
  logic              pend_q;
  logic              commit_q;
  logic              busy_q;
  logic [TIMER_W-1:0] timer_q;
  logic [15:0]       valid_q;
  logic [7:0]        page_q [eeprom_pkg::PAGE_BYTES];
  logic [7:0]        mem_q  [MEM_BYTES];

  event_cross u_cross (
    .clock   (clock),
    .reset_n (reset_n),
    .ev      (lk),
    .valid   (ev_valid),
    .code    (ev_code)
  );

  // Next address, optionally held inside the current page.
  function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a,
                                                  input logic in_page);
    logic [ADDR_W-1:0] n;
    n = a + 1'b1;
    if (in_page) begin
      n[ADDR_W-1:PW] = a[ADDR_W-1:PW];
    end
    return n;
  endfunction

  // The pad pulls an open write-protect pin low, so reset level is low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      wp_m_q <= wp_i;
      wp_s_q <= wp_m_q;
    end
  end

  // Bit and byte sequencing for address, data and acknowledge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= eeprom_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shreg_q  <= 8'h00;
      drive_q  <= 1'b0;
      addr_q   <= '0;
      tx_q     <= 8'h00;
      wp_blk_q <= 1'b0;
      pend_q   <= 1'b0;
      commit_q <= 1'b0;
      valid_q  <= 16'h0000;
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        page_q[i] <= 8'h00;
      end
    end else begin
      commit_q <= 1'b0;
      if (ev_valid) begin
        case (ev_code)
          eeprom_pkg::EV_START: begin
            drive_q  <= 1'b0;
            bitcnt_q <= 4'h0;
            if (busy_q) begin
              state_q <= eeprom_pkg::ST_IDLE;
            end else begin
              state_q  <= eeprom_pkg::ST_DEV;
              pend_q   <= 1'b0;
              wp_blk_q <= 1'b0;
              valid_q  <= 16'h0000;
            end
          end
          eeprom_pkg::EV_STOP: begin
            drive_q <= 1'b0;
            state_q <= eeprom_pkg::ST_IDLE;
            pend_q  <= 1'b0;
            if (pend_q && !wp_blk_q && !wp_s_q && !busy_q) begin
              commit_q <= 1'b1;
            end
          end
          eeprom_pkg::EV_RISE0, eeprom_pkg::EV_RISE1: begin
            if (state_q != eeprom_pkg::ST_IDLE && bitcnt_q < eeprom_pkg::BIT_ACK) begin
              shreg_q  <= {shreg_q[6:0], ev_code == eeprom_pkg::EV_RISE1};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (state_q == eeprom_pkg::ST_RDATA && bitcnt_q == eeprom_pkg::BIT_ACK) begin
              if (ev_code == eeprom_pkg::EV_RISE1) begin
                state_q <= eeprom_pkg::ST_IDLE;
                addr_q  <= addr_next(addr_q, 1'b0);
              end else begin
                bitcnt_q <= eeprom_pkg::BIT_ACK_DONE;
                addr_q   <= addr_next(addr_q, 1'b0);
                tx_q     <= mem_q[addr_next(addr_q, 1'b0)];
              end
            end
          end
          eeprom_pkg::EV_FALL: begin
            if (state_q == eeprom_pkg::ST_RDATA) begin
              if (bitcnt_q == eeprom_pkg::BIT_ACK_DONE) begin
                drive_q  <= ~tx_q[7];
                bitcnt_q <= 4'h0;
              end else if (bitcnt_q == eeprom_pkg::BIT_ACK) begin
                drive_q <= 1'b0;
              end else if (bitcnt_q != 4'h0) begin
                drive_q <= ~tx_q[3'h7 - bitcnt_q[2:0]];
              end
            end else if (state_q != eeprom_pkg::ST_IDLE && bitcnt_q == eeprom_pkg::BIT_ACK) begin
              bitcnt_q <= eeprom_pkg::BIT_ACK_DONE;
              case (state_q)
                eeprom_pkg::ST_DEV: begin
                  if (shreg_q[7:1] == {eeprom_pkg::DEV_TYPE, eeprom_pkg::DEV_SEL}) begin
                    drive_q <= 1'b1;
                    tx_q    <= mem_q[addr_q];
                  end else begin
                    state_q <= eeprom_pkg::ST_IDLE;
                  end
                end
                eeprom_pkg::ST_WORD: begin
                  drive_q <= 1'b1;
                  addr_q  <= shreg_q[ADDR_W-1:0];
                end
                eeprom_pkg::ST_WDATA: begin
                  if (wp_blk_q) begin
                    state_q <= eeprom_pkg::ST_IDLE;
                  end else begin
                    drive_q                <= 1'b1;
                    page_q[addr_q[PW-1:0]]  <= shreg_q;
                    valid_q[addr_q[PW-1:0]] <= 1'b1;
                    pend_q                 <= 1'b1;
                    addr_q                 <= addr_next(addr_q, 1'b1);
                  end
                end
                default: begin
                  state_q <= eeprom_pkg::ST_IDLE;
                end
              endcase
            end else if (state_q != eeprom_pkg::ST_IDLE && bitcnt_q == eeprom_pkg::BIT_ACK_DONE) begin
              bitcnt_q <= 4'h0;
              drive_q  <= 1'b0;
              if (state_q == eeprom_pkg::ST_DEV && shreg_q[0]) begin
                state_q <= eeprom_pkg::ST_RDATA;
                drive_q <= ~tx_q[7];
              end else if (state_q == eeprom_pkg::ST_DEV) begin
                state_q <= eeprom_pkg::ST_WORD;
              end else if (state_q == eeprom_pkg::ST_WORD) begin
                state_q  <= eeprom_pkg::ST_WDATA;
                wp_blk_q <= wp_s_q;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Write cycle timer; the page is copied into the array at its end.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q  <= 1'b0;
      timer_q <= '0;
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_q[i] <= eeprom_pkg::ERASED_BYTE;
      end
    end else if (commit_q) begin
      busy_q  <= 1'b1;
      timer_q <= TIMER_W'(WRITE_CYCLES - 1);
    end else if (busy_q) begin
      if (timer_q == '0) begin
        busy_q <= 1'b0;
        for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
          if (valid_q[i]) begin
            mem_q[{addr_q[ADDR_W-1:PW], PW'(i)}] <= page_q[i];
          end
        end
      end else begin
        timer_q <= timer_q - 1'b1;
      end
    end
  end

  assign write_busy = busy_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int unsigned BUSY_MAX = WRITE_CYCLES;
  logic [TIMER_W:0] busy_cnt_q;

  // Counts the cycles of the current write cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_q ? busy_cnt_q + 1'b1 : '0;
    end
  end

  property p_never_high;
    @(posedge link_clock) disable iff (!reset_n) sda_oe |-> sda_o == 1'b0;
  endproperty
  a_never_high: assert property (p_never_high)
    else $error("Data line driven high.");

  property p_busy_quiet;
    @(posedge clock) disable iff (!reset_n) busy_q |-> !drive_q;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("Acknowledge during write cycle.");

  property p_write_time;
    @(posedge clock) disable iff (!reset_n) busy_cnt_q <= BUSY_MAX;
  endproperty
  a_write_time: assert property (p_write_time)
    else $error("Write cycle too long.");

  property p_addr_match;
    @(posedge clock) disable iff (!reset_n)
      $rose(drive_q) && $past(state_q) == eeprom_pkg::ST_DEV
      |-> $past(shreg_q[7:1]) == {eeprom_pkg::DEV_TYPE, eeprom_pkg::DEV_SEL};
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("Acknowledged a foreign address.");

  property p_wp_reject;
    @(posedge clock) disable iff (!reset_n)
      state_q == eeprom_pkg::ST_WDATA && wp_blk_q |-> !drive_q && !pend_q;
  endproperty
  a_wp_reject: assert property (p_wp_reject)
    else $error("Protected data byte acknowledged.");

  property p_wp_commit;
    @(posedge clock) disable iff (!reset_n) $rose(busy_q) |-> !$past(wp_blk_q, 2);
  endproperty
  a_wp_commit: assert property (p_wp_commit)
    else $error("Write started while protected.");

  property p_page_hold;
    @(posedge clock) disable iff (!reset_n)
      state_q == eeprom_pkg::ST_WDATA && $past(state_q) == eeprom_pkg::ST_WDATA
      |-> $stable(addr_q[ADDR_W-1:PW]);
  endproperty
  a_page_hold: assert property (p_page_hold)
    else $error("Page address moved during page write.");

  property p_read_inc;
    @(posedge clock) disable iff (!reset_n)
      ev_valid && ev_code inside {eeprom_pkg::EV_RISE0, eeprom_pkg::EV_RISE1}
      && state_q == eeprom_pkg::ST_RDATA && bitcnt_q == eeprom_pkg::BIT_ACK
      |=> addr_q == ADDR_W'($past(addr_q) + 1'b1);
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("Read address did not advance.");

  property p_drive_on_fall;
    @(posedge clock) disable iff (!reset_n)
      $changed(drive_q) |-> $past(ev_valid) && $past(ev_code) inside
        {eeprom_pkg::EV_FALL, eeprom_pkg::EV_START, eeprom_pkg::EV_STOP};
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall)
    else $error("Data changed away from a clock fall.");

  c_write: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy_q));
  c_read: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == eeprom_pkg::ST_RDATA && bitcnt_q == eeprom_pkg::BIT_ACK_DONE);
  c_reject: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == eeprom_pkg::ST_WDATA && wp_blk_q);

endmodule

`default_nettype wire

// ---- eeprom_slave_tb.sv ----
// Self-checking bench for the serial EEPROM slave.
// Assumes: the design files and the master model are compiled first.
`default_nettype none

module eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned WC = 4000;

  logic        clock;
  logic        reset_n;
  logic        link_clock;
  logic        wp_en;
  logic        sda_o;
  logic        sda_oe;
  logic        write_busy;
  logic        scl;
  logic        sda_pull;
  wire         sda_line;
  tri0         wp_net;
  int unsigned busy_n;
  int unsigned mismatches;
  int unsigned tests_run;

  // ---------------------------------------------------------------
  // Wiring
  // ---------------------------------------------------------------
  // Open-drain line with pull-up; an undriven write-protect falls low.
  assign sda_line = (sda_pull === 1'b1) ? 1'b0 : (sda_oe === 1'b1) ? sda_o : 1'b1;
  assign wp_net = wp_en ? 1'b1 : 1'bz;

  eeprom_slave #(.MEM_BYTES(256), .WRITE_CYCLES(WC)) dut (
    .clock(clock), .reset_n(reset_n), .link_clock(link_clock), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_net),
    .write_busy(write_busy));

  i2c_master_model m (.clock(clock), .sda(sda_line), .scl(scl), .sda_pull(sda_pull));

  // System clock of 5 ns and an unrelated link clock of 6 ns.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #1.3;
    forever #3 link_clock = ~link_clock;
  end

  // ---------------------------------------------------------------
  // Checking and helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Pin driver, busy state and reset state are watched on every cycle.
  always @(posedge clock) begin
    if (sda_oe === 1'b1) check(8'(sda_o), 8'h0);
    if (write_busy === 1'b1) check(8'(sda_oe), 8'h0);
    if (reset_n === 1'b0) check(8'({sda_oe, write_busy}), 8'h0);
    busy_n <= (write_busy === 1'b1) ? busy_n + 1 : 0;
  end

  // Waits for the busy flag to reach a level, with a bound.
  task automatic wait_busy(input logic lvl, input int unsigned lim);
    int unsigned n;
    n = 0;
    while (write_busy !== lvl) begin
      @(posedge clock);
      #1;
      n++;
      if (n > lim) begin
        mismatches++;
        test_done();
      end
    end
  endtask

  // Sends one byte and compares the acknowledge bit.
  task automatic wr(input logic [7:0] b, input logic exp_nack);
    logic [8:0] rx;
    logic       st;
    m.xfer({b, 1'b1}, rx, st);
    check(8'(rx[0]), 8'(exp_nack));
  endtask

  // Selective read of two bytes, the first acknowledged by the master.
  task automatic rd_at(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [8:0] rx;
    logic       st;
    m.start();
    wr(8'ha0, 1'b0);
    wr(a, 1'b0);
    m.start();
    wr(8'ha1, 1'b0);
    m.xfer(9'h1fe, rx, st);
    check(rx[8:1], e0);
    check(8'(st), 8'h1);
    m.xfer(9'h1ff, rx, st);
    check(rx[8:1], e1);
    m.stop();
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Only the fixed device address is acknowledged.
  task automatic t_address();
    logic [7:0] adr [3] = '{8'ha0, 8'ha2, 8'hb0};
    for (int i = 0; i < 3; i++) begin
      m.start();
      wr(adr[i], i != 0);
      m.stop();
    end
  endtask

  // Page write at the top of the page wraps, then both ends are read back.
  task automatic t_page();
    m.start();
    wr(8'ha0, 1'b0);
    wr(8'hff, 1'b0);
    m.glitch();
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    m.stop();
    wait_busy(1'b1, 20);
    wait_busy(1'b0, WC + 20);
    check(8'(busy_n + 1 >= WC && busy_n <= WC + 1), 8'h1);
    rd_at(8'hff, 8'h11, 8'hff);
    rd_at(8'hf0, 8'h22, 8'hff);
  endtask

  // Write protect held high rejects the first data byte and the write.
  task automatic t_protect();
    wp_en = 1'b1;
    m.start();
    wr(8'ha0, 1'b0);
    wr(8'h10, 1'b0);
    wr(8'h55, 1'b1);
    m.stop();
    repeat (40) @(posedge clock);
    #1;
    check(8'(write_busy), 8'h0);
    wp_en = 1'b0;
  endtask

  // Polling during the write cycle, then a supply reset in mid-cycle.
  task automatic t_reset();
    m.start();
    wr(8'ha0, 1'b0);
    wr(8'h10, 1'b0);
    wr(8'h77, 1'b0);
    m.stop();
    wait_busy(1'b1, 20);
    m.start();
    wr(8'ha0, 1'b1);
    m.stop();
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (40) @(posedge clock);
    rd_at(8'h10, 8'hff, 8'hff);
  endtask

  // Main sequence.
  initial begin
    mismatches = 0;
    tests_run = 0;
    wp_en = 1'b0;
    // A clean falling edge clears both domains before the first clock edge.
    reset_n = 1'b1;
    #1;
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (40) @(posedge clock);
    t_address();
    t_page();
    t_protect();
    t_reset();
    test_done();
  end

endmodule

`default_nettype wire

// ---- event_cross.sv ----
// Toggle crossing of bus events into the system clock domain.
// Assumes: events are at least a few system cycles apart.
`default_nettype none

module event_cross (
  // System clock and reset.
  input  wire logic      clock,
  input  wire logic      reset_n,
  // Events from the link domain.
  event_if.dst           ev,
  // One-cycle event pulse with its code.
  output logic           valid,
  output eeprom_pkg::ev_e code
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Two flip-flops synchronise the toggle, a third finds its edge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= ev.tgl;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // The code is stable by the time the toggle edge is seen.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      valid <= 1'b0;
      code  <= eeprom_pkg::EV_NONE;
    end else begin
      valid <= s2_q ^ s3_q;
      if (s2_q ^ s3_q) begin
        code <= ev.code;
      end
    end
  end

endmodule

`default_nettype wire

// ---- event_if.sv ----
// Carrier for bus events passed from the link domain to the system domain.
// Assumes: the source holds code stable while tgl changes and after it.
`default_nettype none

interface event_if;
  eeprom_pkg::ev_e code;
  logic            tgl;
  modport src (output code, output tgl);
  modport dst (input code, input tgl);
endinterface

`default_nettype wire

// ---- i2c_master_model.sv ----
// Two-wire bus master model that drives the serial clock and the data pull-down.
// Assumes: the bench resolves the open-drain data line with a pull-up.
`default_nettype none

module i2c_master_model #(
  parameter int unsigned PHASE = 124
) (
  // System clock used to time the bus phases.
  input  wire logic clock,
  // Resolved data line.
  input  wire logic sda,
  // Serial clock and data pull-down.
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------
  // The bus starts idle with clock high and data released.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // One phase is at least 600 ns, but a 279-cycle bit runs the clock near 717 kHz, above fast mode.
  task automatic ph(input int unsigned n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Start or repeated start; data is released while the clock is low, then pulled while it is high.
  task automatic start();
    sda_pull = 1'b0;
    ph(PHASE);
    scl = 1'b1;
    ph(PHASE);
    sda_pull = 1'b1;
    ph(PHASE);
    scl = 1'b0;
    ph(PHASE / 4);
  endtask

  // Stop from clock low; the bus is left idle.
  task automatic stop();
    sda_pull = 1'b1;
    ph(PHASE);
    scl = 1'b1;
    ph(PHASE);
    sda_pull = 1'b0;
    ph(PHASE);
  endtask

  // Nine clocks, most significant bit first; the ninth is the acknowledge.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx, output logic steady);
    steady = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      sda_pull = ~tx[i];
      ph(PHASE);
      scl = 1'b1;
      ph(PHASE / 2);
      rx[i] = sda;
      ph(PHASE / 2);
      steady &= (sda === rx[i]);
      scl = 1'b0;
      ph(PHASE / 4);
    end
  endtask

  // A 60 ns clock pulse while the clock is low must be filtered out.
  task automatic glitch();
    scl = 1'b1;
    #60;
    scl = 1'b0;
    ph(1);
  endtask

endmodule

`default_nettype wire

// ---- pin_filter.sv ----
// Synchroniser and glitch filter for one bus pin.
// Assumes: the pin is asynchronous to clock and idles high.
`default_nettype none

module pin_filter #(
  parameter int unsigned STABLE_CYCLES = eeprom_pkg::GLITCH_CYCLES
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset_n,
  // Raw pin and filtered level.
  input  wire logic pin,
  output logic      level
);

  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

  logic          meta_q;
  logic          sync_q;
  logic [CW-1:0] cnt_q;

  if (STABLE_CYCLES < 1) begin : g_chk
    $error("pin_filter needs at least one stable cycle.");
  end

  // Two flip-flops bring the pin into the clock domain.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // A new level is taken only after it outlasts the glitch width.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b1;
      cnt_q <= '0;
    end else if (sync_q == level) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(STABLE_CYCLES)) begin
      level <= sync_q;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

`default_nettype wire
